// *** logic/sbs_cfg.svh ***
`ifndef SBS_CFG_SVH
`define SBS_CFG_SVH

// ---------------------------------------------------------------
// Register map (byte addresses, one aligned word each)
// ---------------------------------------------------------------
`define SBS_ADDR_W          12
`define SBS_ADDR_STRAP      12'h000
`define SBS_ADDR_STATUS     12'h004
`define SBS_ADDR_CTRL       12'h008

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define SBS_STRAP_PRINT_BIT 0
`define SBS_STRAP_BOOT_BIT  1
`define SBS_STAT_FLASH_BIT  0
`define SBS_STAT_DLOAD_BIT  1
`define SBS_STAT_INVAL_BIT  2
`define SBS_STAT_LOG_BIT    3
`define SBS_STAT_FUSE_LSB   4
`define SBS_STAT_RUN_BIT    6
`define SBS_CTRL_PULL_BIT   0

// ---------------------------------------------------------------
// Reset values and fuse codes
// ---------------------------------------------------------------
`define SBS_STRAP_RST       2'h3
`define SBS_CTRL_PULL_RST   1'h1
`define SBS_FUSE_LOG_ON     2'h0
`define SBS_FUSE_LOG_LOW    2'h1
`define SBS_FUSE_LOG_HIGH   2'h2
`define SBS_FUSE_LOG_OFF    2'h3

`endif

// *** logic/sbs_pkg.sv ***
`default_nettype none

package sbs_pkg;

	// Power and reset phase of the strap latch
	typedef enum logic [1:0] {
		ST_OFF,
		ST_RESET,
		ST_RUN
	} sbs_state_t;

endpackage : sbs_pkg

`default_nettype wire

// *** logic/sbs_sync2.sv ***
`timescale 1ns/1ps
`default_nettype none

// Two-stage synchroniser; the first stage feeds only the second
module sbs_sync2 #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         reset_n,
	input  wire logic         clk_en,
	input  wire logic [W-1:0] async_i,
	output logic      [W-1:0] sync_o
);

	logic [W-1:0] meta_q;
	logic [W-1:0] meta_d;
	logic [W-1:0] sync_d;

	// Hold both stages while the clock enable is low
	always_comb begin
		meta_d = clk_en ? async_i : meta_q;
		sync_d = clk_en ? meta_q : sync_o;
	end

	// Stage registers
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			meta_q <= '0;
			sync_o <= '0;
		end else begin
			meta_q <= meta_d;
			sync_o <= sync_d;
		end
	end

endmodule : sbs_sync2

`default_nettype wire

// *** logic/sbs_strap_latch.sv ***
//
// Function
// - Chip runs while chip enable is high and powers off while low.
// - During system reset both strap pins are sampled as 0 or 1 bits.
// - Latched strap bits hold until power-down or the next reset release; later pin activity is ignored.
// - Power-on, always-on watchdog, brownout and super watchdog resets all recapture.
// - Both latched bits are readable by software in the strap value register.
// - Boot select pin has a weak pull-up by default; floating reads as 1.
// - After reset both pins return to ordinary I/O; pins no longer matter.
// - Boot select 1 means flash boot; 0 with print strap 1 means download.
// - Fuse 1: log on when print strap is 0, off when 1.
// - Fuse 2: log off when print strap is 0, on when 1.
// - Fuse 0 always enables log, fuse 3 always disables; strap ignored.
//
`timescale 1ns/1ps
`default_nettype none
`include "sbs_cfg.svh"

module sbs_strap_latch (
	input  wire logic                   clk,
	input  wire logic                   reset_n,
	input  wire logic                   clk_en,
	// Pins, asynchronous to clk
	input  wire logic                   chip_en_pin,
	input  wire logic                   print_strap_pin_i,
	input  wire logic                   boot_select_pin_i,
	output logic                        print_strap_pin_o,
	output logic                        print_strap_pin_oe,
	output logic                        boot_select_pin_o,
	output logic                        boot_select_pin_oe,
	output logic                        boot_select_pullup,
	// Ordinary I/O function of the pins, same clock
	input  wire logic                   gpio_print_o,
	input  wire logic                   gpio_print_oe,
	input  wire logic                   gpio_boot_o,
	input  wire logic                   gpio_boot_oe,
	// Reset sources, same clock, level
	input  wire logic                   por_rst,
	input  wire logic                   aon_wdt_rst,
	input  wire logic                   brownout_rst,
	input  wire logic                   super_wdt_rst,
	input  wire logic [1:0]             rom_log_select_fuse,
	// Boot decisions
	output logic                        chip_run,
	output logic                        sys_reset,
	output logic                        boot_from_flash,
	output logic                        download_boot,
	output logic                        strap_invalid,
	output logic                        rom_log_en,
	// APB slave
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [`SBS_ADDR_W-1:0] paddr,
	input  wire logic [31:0]            pwdata,
	output logic                        pready,
	output logic [31:0]                 prdata,
	output logic                        pslverr
);

	// ---------------------------------------------------------------
	// Pin synchronisers
	// ---------------------------------------------------------------
	logic [2:0] pins_s;
	logic       en_s;
	logic       print_s;
	logic       boot_s;

	sbs_sync2 #(
		.W (3)
	) u_sync (
		.clk     (clk),
		.reset_n (reset_n),
		.clk_en  (clk_en),
		.async_i ({chip_en_pin, boot_select_pin_i, print_strap_pin_i}),
		.sync_o  (pins_s)
	);

	// Split of the synchronised pin levels
	assign en_s    = pins_s[2];
	assign boot_s  = pins_s[1];
	assign print_s = pins_s[0];

	// ---------------------------------------------------------------
	// Decode functions
	// ---------------------------------------------------------------
	function automatic logic rom_log_fn(input logic [1:0] fuse, input logic print);
		logic en;
		en = 1'b1;
		unique case (fuse)
			`SBS_FUSE_LOG_ON:   en = 1'b1;
			`SBS_FUSE_LOG_LOW:  en = ~print;
			`SBS_FUSE_LOG_HIGH: en = print;
			`SBS_FUSE_LOG_OFF:  en = 1'b0;
		endcase
		return en;
	endfunction : rom_log_fn

	function automatic logic is_addr(input logic [`SBS_ADDR_W-1:0] a,
		input logic [`SBS_ADDR_W-1:0] r);
		return a == r;
	endfunction : is_addr

	// ---------------------------------------------------------------
	// Power and reset sequencing
	// ---------------------------------------------------------------
	sbs_pkg::sbs_state_t state_q;
	sbs_pkg::sbs_state_t state_d;
	logic                any_src;
	logic                capture;

	// Any documented reset source holds the system in reset
	assign any_src = por_rst | aon_wdt_rst | brownout_rst | super_wdt_rst;

	// Next phase; chip enable low overrides every reset source
	always_comb begin
		state_d = state_q;
		capture = 1'b0;
		if (clk_en) begin
			unique case (state_q)
				sbs_pkg::ST_OFF: begin
					if (en_s) state_d = sbs_pkg::ST_RESET;
				end
				sbs_pkg::ST_RESET: begin
					if (!en_s) begin
						state_d = sbs_pkg::ST_OFF;
					end else if (!any_src) begin
						state_d = sbs_pkg::ST_RUN;
						capture = 1'b1;
					end
				end
				sbs_pkg::ST_RUN: begin
					if (!en_s) state_d = sbs_pkg::ST_OFF;
					else if (any_src) state_d = sbs_pkg::ST_RESET;
				end
				default: state_d = sbs_pkg::ST_OFF; // Unused code falls back to off
			endcase
		end
	end

	// Phase register
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) state_q <= sbs_pkg::ST_OFF;
		else state_q <= state_d;
	end

	// ---------------------------------------------------------------
	// Strap latch and boot decisions
	// ---------------------------------------------------------------
	logic [1:0] strap_q;
	logic [1:0] strap_d;
	logic       run_d;
	logic       rst_d;
	logic       flash_d;
	logic       dload_d;
	logic       inval_d;
	logic       log_d;

	// Decisions follow the next strap value so outputs stay in step with it
	always_comb begin
		strap_d = strap_q;
		if (clk_en && state_d == sbs_pkg::ST_OFF) begin
			strap_d = `SBS_STRAP_RST; // Contents lost at power-down
		end else if (capture) begin
			strap_d = {boot_s, print_s};
		end
		// Otherwise the pins are not looked at
		run_d   = state_d != sbs_pkg::ST_OFF;
		rst_d   = state_d == sbs_pkg::ST_RESET;
		flash_d = strap_d[`SBS_STRAP_BOOT_BIT];
		dload_d = ~strap_d[`SBS_STRAP_BOOT_BIT] & strap_d[`SBS_STRAP_PRINT_BIT];
		inval_d = ~strap_d[`SBS_STRAP_BOOT_BIT] & ~strap_d[`SBS_STRAP_PRINT_BIT];
		log_d   = rom_log_fn(rom_log_select_fuse, strap_d[`SBS_STRAP_PRINT_BIT]);
		if (!clk_en) begin
			run_d   = chip_run;
			rst_d   = sys_reset;
			log_d   = rom_log_en;
		end
	end

	// Latch and decision registers
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			strap_q         <= `SBS_STRAP_RST;
			chip_run        <= 1'b0;
			sys_reset       <= 1'b0;
			boot_from_flash <= 1'b1;
			download_boot   <= 1'b0;
			strap_invalid   <= 1'b0;
			rom_log_en      <= 1'b1;
		end else begin
			strap_q         <= strap_d;
			chip_run        <= run_d;
			sys_reset       <= rst_d;
			boot_from_flash <= flash_d;
			download_boot   <= dload_d;
			strap_invalid   <= inval_d;
			rom_log_en      <= log_d;
		end
	end

	// ---------------------------------------------------------------
	// Pad control
	// ---------------------------------------------------------------
	logic ctrl_pull_q;
	logic ctrl_pull_d;
	logic pad_po_d;
	logic pad_poe_d;
	logic pad_bo_d;
	logic pad_boe_d;
	logic pull_d;

	// Pins stay inputs outside run so nothing fights the strap level
	always_comb begin
		pad_po_d  = print_strap_pin_o;
		pad_poe_d = print_strap_pin_oe;
		pad_bo_d  = boot_select_pin_o;
		pad_boe_d = boot_select_pin_oe;
		pull_d    = boot_select_pullup;
		if (clk_en) begin
			if (state_d == sbs_pkg::ST_RUN) begin
				pad_po_d  = gpio_print_o;
				pad_poe_d = gpio_print_oe;
				pad_bo_d  = gpio_boot_o;
				pad_boe_d = gpio_boot_oe;
				pull_d    = ctrl_pull_q;
			end else begin
				pad_po_d  = 1'b0;
				pad_poe_d = 1'b0;
				pad_bo_d  = 1'b0;
				pad_boe_d = 1'b0;
				pull_d    = 1'b1;
			end
		end
	end

	// Pad registers
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			print_strap_pin_o  <= 1'b0;
			print_strap_pin_oe <= 1'b0;
			boot_select_pin_o  <= 1'b0;
			boot_select_pin_oe <= 1'b0;
			boot_select_pullup <= 1'b1;
		end else begin
			print_strap_pin_o  <= pad_po_d;
			print_strap_pin_oe <= pad_poe_d;
			boot_select_pin_o  <= pad_bo_d;
			boot_select_pin_oe <= pad_boe_d;
			boot_select_pullup <= pull_d;
		end
	end

	// ---------------------------------------------------------------
	// APB slave
	// ---------------------------------------------------------------
	logic        setup;
	logic        access;
	logic        pready_d;
	logic        pslverr_d;
	logic [31:0] prdata_d;
	logic        mapped;

	// Answer is prepared in setup, so the access phase lasts one cycle
	assign setup  = clk_en & psel & ~penable;
	assign access = clk_en & psel & penable & pready;
	assign mapped = is_addr(paddr, `SBS_ADDR_STRAP) | is_addr(paddr, `SBS_ADDR_STATUS)
		| is_addr(paddr, `SBS_ADDR_CTRL);

	// Read mux, error and the one writable bit
	always_comb begin
		pready_d    = clk_en ? setup : pready;
		pslverr_d   = clk_en ? (setup & ~mapped) : pslverr;
		prdata_d    = prdata;
		ctrl_pull_d = ctrl_pull_q;
		if (setup) begin
			prdata_d = 32'h0000_0000;
			if (!pwrite && is_addr(paddr, `SBS_ADDR_STRAP)) begin
				prdata_d[1:0] = strap_q;
			end else if (!pwrite && is_addr(paddr, `SBS_ADDR_STATUS)) begin
				prdata_d[`SBS_STAT_FLASH_BIT] = boot_from_flash;
				prdata_d[`SBS_STAT_DLOAD_BIT] = download_boot;
				prdata_d[`SBS_STAT_INVAL_BIT] = strap_invalid;
				prdata_d[`SBS_STAT_LOG_BIT]   = rom_log_en;
				prdata_d[`SBS_STAT_FUSE_LSB +: 2] = rom_log_select_fuse;
				prdata_d[`SBS_STAT_RUN_BIT]   = chip_run;
			end else if (!pwrite && is_addr(paddr, `SBS_ADDR_CTRL)) begin
				prdata_d[`SBS_CTRL_PULL_BIT] = ctrl_pull_q;
			end
		end
		// Strap register ignores writes; it is a status field only
		if (access && pwrite && is_addr(paddr, `SBS_ADDR_CTRL)) begin
			ctrl_pull_d = pwdata[`SBS_CTRL_PULL_BIT];
		end
	end

	// Bus registers
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pready      <= 1'b0;
			pslverr     <= 1'b0;
			prdata      <= 32'h0000_0000;
			ctrl_pull_q <= `SBS_CTRL_PULL_RST;
		end else begin
			pready      <= pready_d;
			pslverr     <= pslverr_d;
			prdata      <= prdata_d;
			ctrl_pull_q <= ctrl_pull_d;
		end
	end

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk iff clk_en);
	endclocking
	default disable iff (!reset_n);

	sequence s_release;
		(state_q == sbs_pkg::ST_RESET) && en_s && !any_src;
	endsequence

	sequence s_strap_read;
		psel && !penable && !pwrite && (paddr == `SBS_ADDR_STRAP);
	endsequence

	power_off_a: assert property (
		(state_q != sbs_pkg::ST_OFF) && !en_s |=> !chip_run && (state_q == sbs_pkg::ST_OFF))
		else $error("chip did not power off on chip enable low");

	capture_release_a: assert property (
		s_release |=> (strap_q == $past({boot_s, print_s})) && (state_q == sbs_pkg::ST_RUN))
		else $error("strap not captured at reset release");

	strap_hold_a: assert property (
		(state_q == sbs_pkg::ST_RUN) ##1 (state_q == sbs_pkg::ST_RUN) |-> $stable(strap_q))
		else $error("strap bits changed while running");

	source_reset_a: assert property (
		(state_q == sbs_pkg::ST_RUN) && en_s && any_src |=> sys_reset ##1 1'b1)
		else $error("reset source did not restart the strap phase");

	strap_read_a: assert property (
		s_strap_read |=> pready && (prdata[1:0] == $past(strap_q)) && !pslverr)
		else $error("strap register read wrong");

	pullup_reset_a: assert property (
		(state_q != sbs_pkg::ST_RUN) |-> boot_select_pullup)
		else $error("boot select pull-up off outside run");

	pin_release_a: assert property (
		(state_q != sbs_pkg::ST_RUN) |-> !print_strap_pin_oe && !boot_select_pin_oe)
		else $error("strap pin driven during reset");

	boot_decode_a: assert property (
		(boot_from_flash == strap_q[1]) && (download_boot == (!strap_q[1] && strap_q[0])))
		else $error("boot mode does not match latched straps");

	log_low_a: assert property (
		$past(rom_log_select_fuse) == 2'h1 |-> rom_log_en == !strap_q[0])
		else $error("fuse 1 log decode wrong");

	log_high_a: assert property (
		$past(rom_log_select_fuse) == 2'h2 |-> rom_log_en == strap_q[0])
		else $error("fuse 2 log decode wrong");

	log_fixed_a: assert property (
		$past(rom_log_select_fuse) == 2'h0 |-> rom_log_en)
		else $error("fuse 0 did not force log on");

	log_off_a: assert property (
		$past(rom_log_select_fuse) == 2'h3 |-> !rom_log_en)
		else $error("fuse 3 did not force log off");

	capture_only_a: assert property (
		$changed(strap_q) |-> $past(state_q == sbs_pkg::ST_RESET) || !chip_run)
		else $error("strap changed outside reset release");

endmodule : sbs_strap_latch

`default_nettype wire

// *** dv/sbs_pin_host.sv ***
`timescale 1ns/1ps
`default_nettype none

// ---------------------------------------------------------------
// Board side of the two strap pins
// ---------------------------------------------------------------
// Host GPIO and device pad resolved onto each pin, plus the weak pull on boot select only
module sbs_pin_host (
	input  wire logic clk,
	input  wire logic host_print_oe,
	input  wire logic host_print_v,
	input  wire logic host_boot_oe,
	input  wire logic host_boot_v,
	input  wire logic dev_print_o,
	input  wire logic dev_print_oe,
	input  wire logic dev_boot_o,
	input  wire logic dev_boot_oe,
	input  wire logic dev_pull,
	output logic      print_strap_pin,
	output logic      boot_select_pin
);
	logic print_q = 1'b0;
	logic boot_q  = 1'b0;

	// Last levels, so a line nobody holds keeps changing
	always @(posedge clk) begin
		print_q <= print_strap_pin;
		boot_q  <= boot_select_pin;
	end

	// No pull on the print strap: a floating line is not a stable 0 or 1
	assign print_strap_pin = host_print_oe ? host_print_v : dev_print_oe ? dev_print_o : ~print_q;
	// Weak pull-up decides only when neither side drives
	assign boot_select_pin = host_boot_oe ? host_boot_v : dev_boot_oe ? dev_boot_o :
		dev_pull ? 1'b1 : ~boot_q;
endmodule : sbs_pin_host

`default_nettype wire

// *** dv/test_strap_latch_boot_select.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "sbs_cfg.svh"

module test_strap_latch_boot_select;
	logic                   clk, reset_n, chip_en, psel, penable, pwrite, pready, pslverr;
	logic [`SBS_ADDR_W-1:0] paddr;
	logic [31:0]            pwdata, prdata, rd;
	logic                   err, ps_oe, ps_v, bs_oe, bs_v, ps_pin, bs_pin, p, b, lg, ce;
	logic                   ps_o, ps_doe, bs_o, bs_doe, bs_pull, g_po, g_poe, g_bo, g_boe;
	logic [3:0]             src;
	logic [1:0]             fuse, f, prev;
	logic                   chip_run, sys_reset, flash, dload, inval, log_en;
	int                     error_cnt, comparisons, cyc;

	// ---------------------------------------------------------------
	// Design and board
	// ---------------------------------------------------------------
	sbs_strap_latch i_sbs_strap_latch (
		.clk(clk), .reset_n(reset_n), .clk_en(ce), .chip_en_pin(chip_en),
		.print_strap_pin_i(ps_pin), .boot_select_pin_i(bs_pin),
		.print_strap_pin_o(ps_o), .print_strap_pin_oe(ps_doe),
		.boot_select_pin_o(bs_o), .boot_select_pin_oe(bs_doe), .boot_select_pullup(bs_pull),
		.gpio_print_o(g_po), .gpio_print_oe(g_poe), .gpio_boot_o(g_bo), .gpio_boot_oe(g_boe),
		.por_rst(src[0]), .aon_wdt_rst(src[1]), .brownout_rst(src[2]), .super_wdt_rst(src[3]),
		.rom_log_select_fuse(fuse), .chip_run(chip_run), .sys_reset(sys_reset),
		.boot_from_flash(flash), .download_boot(dload), .strap_invalid(inval),
		.rom_log_en(log_en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr)
	);

	sbs_pin_host i_sbs_pin_host (
		.clk(clk), .host_print_oe(ps_oe), .host_print_v(ps_v), .host_boot_oe(bs_oe),
		.host_boot_v(bs_v), .dev_print_o(ps_o), .dev_print_oe(ps_doe), .dev_boot_o(bs_o),
		.dev_boot_oe(bs_doe), .dev_pull(bs_pull), .print_strap_pin(ps_pin),
		.boot_select_pin(bs_pin)
	);

	// 25 MHz clock
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// Hang guard; a full run needs well under a thousand cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			error_cnt++;
			report_and_stop();
		end
	end

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("FAIL %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	// One APB transfer; request held until pready is sampled high
	task automatic apb(input logic wr, input logic [`SBS_ADDR_W-1:0] a, input logic [31:0] wd);
		psel   <= 1'b1;
		pwrite <= wr;
		paddr  <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		rd  = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb

	// Bounded wait on chip_run or sys_reset
	task automatic wait_for(input bit run_sig, input logic want);
		repeat (20) begin
			if ((run_sig ? chip_run : sys_reset) === want) return;
			@(posedge clk);
		end
		chk(run_sig ? "chip_run" : "sys_reset", want, run_sig ? chip_run : sys_reset);
	endtask : wait_for

	// Power off, set straps and fuse, power on and wait for the run phase
	task automatic boot(input logic pv, input logic bv, input logic fl, input logic [1:0] fv);
		chip_en <= 1'b0;
		ps_oe   <= 1'b1;
		ps_v    <= pv;
		bs_oe   <= ~fl;
		bs_v    <= bv;
		fuse    <= fv;
		@(posedge clk);
		wait_for(1'b1, 1'b0);
		chip_en <= 1'b1;
		wait_for(1'b0, 1'b1);
		wait_for(1'b0, 1'b0);
		@(posedge clk);
		chk("chip_run", 1, chip_run);
	endtask : boot

	task automatic report_and_stop;
		$display("Comparisons %0d, mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : report_and_stop

	// ---------------------------------------------------------------
	// Test sequence
	// ---------------------------------------------------------------
	initial begin
		{reset_n, chip_en, psel, penable, pwrite, ps_oe, ps_v, bs_oe, bs_v} <= '0;
		{g_po, g_poe, g_bo, g_boe, src, fuse, paddr, pwdata} <= '0;
		ce <= 1'b1;
		repeat (2) @(posedge clk);
		chk("chip_run", 0, chip_run);
		reset_n <= 1'b1;
		// Every legal strap pair and every fuse code; the last boot floats boot select
		for (int i = 0; i < 8; i++) begin
			p = i[2];
			b = p ? i[0] : 1'b1;
			f = i[1:0];
			boot(p, b, i == 7, f);
			b  = b | (i == 7);
			lg = (f == 2'h0) | (f == 2'h1 & !p) | (f == 2'h2 & p);
			chk("flash", b, flash);
			chk("download", !b & p, dload);
			chk("invalid", 0, inval);
			chk("rom_log", lg, log_en);
			apb(1'b0, `SBS_ADDR_STRAP, 0);
			chk("strap", {b, p}, rd);
			apb(1'b0, `SBS_ADDR_STATUS, 0);
			chk("status", {1'b1, f, lg, 1'b0, !b & p, b}, rd);
		end
		// Pins handed back to ordinary I/O; later pin levels are ignored
		ps_v  <= 1'b0;
		g_boe <= 1'b1;
		g_bo  <= 1'b1;
		repeat (4) @(posedge clk);
		chk("boot_oe", 1, bs_doe);
		chk("boot_o", 1, bs_o);
		chk("print_oe", 0, ps_doe);
		g_poe <= 1'b1;
		g_po  <= 1'b1;
		repeat (2) @(posedge clk);
		chk("print_oe", 1, ps_doe);
		chk("print_o", 1, ps_o);
		apb(1'b1, `SBS_ADDR_STRAP, 0);
		apb(1'b0, `SBS_ADDR_STRAP, 0);
		chk("strap", 3, rd);
		apb(1'b1, `SBS_ADDR_CTRL, 0);
		repeat (2) @(posedge clk);
		chk("pullup", 0, bs_pull);
		apb(1'b0, 12'hffc, 0);
		chk("pslverr", 1, err);
		chk("unmapped", 0, rd);
		// Clock enable low freezes the phase, even with a reset source raised
		ce  <= 1'b0;
		src <= 4'h1;
		repeat (4) @(posedge clk);
		chk("frozen_reset", 0, sys_reset);
		chk("frozen_run", 1, chip_run);
		ce  <= 1'b1;
		src <= 4'h0;
		@(posedge clk);
		// Each reset source recaptures, and only at its release
		g_boe <= 1'b0;
		g_poe <= 1'b0;
		prev = 2'h3;
		for (int s = 0; s < 4; s++) begin
			p = s[0];
			b = !s[0] | s[1];
			bs_oe <= 1'b1;
			bs_v  <= b;
			ps_v  <= p;
			src   <= 4'h1 << s;
			@(posedge clk);
			wait_for(1'b0, 1'b1);
			repeat (4) @(posedge clk);
			apb(1'b0, `SBS_ADDR_STRAP, 0);
			chk("strap_held", prev, rd);
			src <= 4'h0;
			wait_for(1'b0, 1'b0);
			@(posedge clk);
			apb(1'b0, `SBS_ADDR_STRAP, 0);
			chk("strap_new", {b, p}, rd);
			prev = {b, p};
		end
		report_and_stop();
	end
endmodule : test_strap_latch_boot_select

`default_nettype wire
